/* core/group_fifo.sv */
// Group store: sixteen accepted groups with their error levels
`timescale 1ns/10ps
`default_nettype none
module group_fifo
  import rds_filter_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             wr_valid,
  input  wire group_s           wr_data,
  output logic                  wr_ready,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output group_s                rd_data,
  output logic [CNT_W-1:0]      count
);

  group_s              mem [FIFO_DEPTH];
  logic [PTR_W-1:0]    wr_ptr_q;
  logic [PTR_W-1:0]    rd_ptr_q;
  logic [CNT_W-1:0]    count_q;
  logic [CNT_W-1:0]    count_d;
  wire                 push;
  wire                 pop;

  assign wr_ready = (count_q != FIFO_FULL);
  assign rd_valid = (count_q != '0);
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;
  assign rd_data  = mem[rd_ptr_q];
  assign count    = count_q;
  assign count_d  = push && !pop ? count_q + CNT_W'(1) :
                    pop && !push ? count_q - CNT_W'(1) : count_q;

  // No reset on storage; only the pointers and the count define what is valid
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_q] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      wr_ptr_q <= push ? wr_ptr_q + PTR_W'(1) : wr_ptr_q;
      rd_ptr_q <= pop ? rd_ptr_q + PTR_W'(1) : rd_ptr_q;
      count_q  <= count_d;
    end
  end

endmodule
`default_nettype wire

/* core/rds_group_filter.sv */
// Group filter with error limits, confidence gating, group store and interrupt
//
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module rds_group_filter
  import rds_filter_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        group_valid,
  input  wire group_s      group_in,
  input  wire conf_s       conf_in,
  output logic             data_service_interrupt
);

  typedef enum logic [1:0] {
    APB_IDLE   = 2'b00,
    APB_ANSWER = 2'b01
  } apb_state_e;

  function automatic logic [1:0] lim_field(input logic [15:0] cfg, input int lsb);
    lim_field = cfg[lsb +: 2];
  endfunction

  // Decoder confidence below the setting demotes the block to uncorrectable
  function automatic logic [1:0] gate_level(input logic [1:0] lvl, input logic [3:0] conf,
                                            input logic [3:0] thr);
    gate_level = (conf < thr) ? LVL_UNCORR : lvl;
  endfunction

  apb_state_e            state_q;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [31:0]           prdata_q;
  logic                  irq_q;
  logic                  power_q;
  logic [7:0]            fifo_level_threshold_q;
  logic [15:0]           filt_cfg_q;
  logic [15:0]           conf_q;
  logic [IRQ_W-1:0]      irq_sts_q;
  logic [IRQ_W-1:0]      irq_sts_d;
  logic [IRQ_W-1:0]      irq_en_q;
  logic                  stored_q;

  wire                   access;
  wire                   access_done;
  wire                   wr_ok;
  wire                   is_thr;
  wire                   is_cfg;
  wire                   is_conf;
  wire                   is_prop;
  wire                   is_own;
  wire                   acc_err;
  wire                   prop_written;
  wire [31:0]            rd_word;
  wire                   group_processing_enable;
  wire [1:0]             first_block_error_limit;
  wire [1:0]             second_block_error_limit;
  wire [1:0]             third_block_error_limit;
  wire [1:0]             fourth_block_error_limit;
  wire [3:0]             second_block_confidence;
  wire [3:0]             third_block_confidence;
  wire [3:0]             fourth_block_confidence;
  wire [1:0]             eff_lvl_a;
  wire [1:0]             eff_lvl_b;
  wire [1:0]             eff_lvl_c;
  wire [1:0]             eff_lvl_d;
  wire                   admit;
  wire                   fifo_wr_valid;
  wire                   fifo_wr_ready;
  group_s                fifo_wr_data;
  wire                   fifo_rd_valid;
  wire                   fifo_rd_ready;
  group_s                fifo_rd_data;
  wire [CNT_W-1:0]       fifo_count;
  wire                   group_threshold_flag;
  wire [IRQ_W-1:0]       irq_set;
  wire [IRQ_W-1:0]       irq_clr;

  // Register bus decode
  assign access       = psel & penable;
  assign access_done  = access & (state_q == APB_ANSWER);
  assign wr_ok        = access_done & pwrite & ~pslverr_q;
  assign is_thr       = (paddr == ADDR_FIFO_THR);
  assign is_cfg       = (paddr == ADDR_FILT_CFG);
  assign is_conf      = (paddr == ADDR_CONF);
  assign is_prop      = is_thr | is_cfg | is_conf;
  assign is_own       = (paddr == ADDR_POWER) | (paddr == ADDR_GROUP_AB) | (paddr == ADDR_GROUP_CD) |
                        (paddr == ADDR_GROUP_STS) | (paddr == ADDR_GROUP_POP) | (paddr == ADDR_IRQ_STS) |
                        (paddr == ADDR_IRQ_EN) | (paddr == ADDR_IRQ_CLR);
  // Settings are refused while powered down; oversize threshold refused
  assign acc_err      = ~(is_prop | is_own) | (is_prop & ~power_q) |
                        (pwrite & is_thr & (pwdata[7:0] > FIFO_THR_MAX));
  assign prop_written = wr_ok & is_prop;

  assign rd_word = is_thr  ? {24'h000000, fifo_level_threshold_q} :
                   is_cfg  ? {16'h0000, filt_cfg_q} :
                   is_conf ? {16'h0000, conf_q} :
                   (paddr == ADDR_POWER)     ? {31'h00000000, power_q} :
                   (paddr == ADDR_GROUP_AB)  ? {fifo_rd_data.blk_a, fifo_rd_data.blk_b} :
                   (paddr == ADDR_GROUP_CD)  ? {fifo_rd_data.blk_c, fifo_rd_data.blk_d} :
                   (paddr == ADDR_GROUP_STS) ? {11'h000, fifo_count, 7'h00, fifo_rd_valid,
                                                fifo_rd_data.lvl_a, fifo_rd_data.lvl_b,
                                                fifo_rd_data.lvl_c, fifo_rd_data.lvl_d} :
                   (paddr == ADDR_IRQ_STS)   ? {29'h00000000, irq_sts_q} :
                   (paddr == ADDR_IRQ_EN)    ? {29'h00000000, irq_en_q} : 32'h00000000;

  // Field extraction
  assign group_processing_enable  = filt_cfg_q[CFG_ENABLE_BIT];
  assign first_block_error_limit  = lim_field(filt_cfg_q, CFG_LIM_A_LSB);
  assign second_block_error_limit = lim_field(filt_cfg_q, CFG_LIM_B_LSB);
  assign third_block_error_limit  = lim_field(filt_cfg_q, CFG_LIM_C_LSB);
  assign fourth_block_error_limit = lim_field(filt_cfg_q, CFG_LIM_D_LSB);
  assign second_block_confidence  = conf_q[CONF_B_LSB +: 4];
  assign third_block_confidence   = conf_q[CONF_C_LSB +: 4];
  assign fourth_block_confidence  = conf_q[CONF_D_LSB +: 4];

  // Block A has no confidence setting
  assign eff_lvl_a = group_in.lvl_a;
  assign eff_lvl_b = gate_level(group_in.lvl_b, conf_in.conf_b, second_block_confidence);
  assign eff_lvl_c = gate_level(group_in.lvl_c, conf_in.conf_c, third_block_confidence);
  assign eff_lvl_d = gate_level(group_in.lvl_d, conf_in.conf_d, fourth_block_confidence);

  assign admit = (eff_lvl_a <= first_block_error_limit) & (eff_lvl_b <= second_block_error_limit) &
                 (eff_lvl_c <= third_block_error_limit) & (eff_lvl_d <= fourth_block_error_limit);
  assign fifo_wr_valid = group_valid & group_processing_enable & admit;
  assign fifo_wr_data  = '{blk_a: group_in.blk_a, blk_b: group_in.blk_b,
                           blk_c: group_in.blk_c, blk_d: group_in.blk_d,
                           lvl_a: eff_lvl_a, lvl_b: eff_lvl_b,
                           lvl_c: eff_lvl_c, lvl_d: eff_lvl_d};
  assign fifo_rd_ready = wr_ok & (paddr == ADDR_GROUP_POP) & pwdata[POP_BIT];

  // Checked one cycle after a store so the count already includes it
  assign group_threshold_flag = stored_q & ({3'b000, fifo_count} >= fifo_level_threshold_q);

  assign irq_set   = {fifo_wr_valid & ~fifo_wr_ready, prop_written, group_threshold_flag};
  assign irq_clr   = (wr_ok & (paddr == ADDR_IRQ_CLR)) ? pwdata[IRQ_W-1:0] : '0;
  // A set in the clearing cycle survives
  assign irq_sts_d = (irq_sts_q & ~irq_clr) | irq_set;

  group_fifo u_fifo (
    .pclk     (pclk),
    .presetn  (presetn),
    .wr_valid (fifo_wr_valid),
    .wr_data  (fifo_wr_data),
    .wr_ready (fifo_wr_ready),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_data),
    .count    (fifo_count)
  );

  // Bus handshake: one wait state, effects at the edge that samples pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= APB_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else begin
      unique case (state_q)
        APB_IDLE: begin
          if (access) begin
            state_q   <= APB_ANSWER;
            pready_q  <= 1'b1;
            pslverr_q <= acc_err;
            prdata_q  <= (pwrite | acc_err) ? 32'h00000000 : rd_word;
          end
        end
        APB_ANSWER: begin
          state_q   <= APB_IDLE;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_q                <= 1'b0;
      fifo_level_threshold_q <= FIFO_THR_RST;
      filt_cfg_q             <= FILT_CFG_RST;
      conf_q                 <= CONF_RST;
      irq_en_q               <= '0;
    end else if (wr_ok) begin
      if (paddr == ADDR_POWER) power_q <= pwdata[POWER_UP_BIT];
      if (is_thr) fifo_level_threshold_q <= pwdata[7:0];
      if (is_cfg) filt_cfg_q <= {pwdata[15:8], 7'h00, pwdata[CFG_ENABLE_BIT]};
      if (is_conf) conf_q <= {4'h0, pwdata[11:0]};
      if (paddr == ADDR_IRQ_EN) irq_en_q <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_sts_q <= '0;
      irq_q     <= 1'b0;
      stored_q  <= 1'b0;
    end else begin
      irq_sts_q <= irq_sts_d;
      irq_q     <= |(irq_sts_q & irq_en_q);
      stored_q  <= fifo_wr_valid & fifo_wr_ready;
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign data_service_interrupt = irq_q;

  property p_thr_flag_level;
    @(posedge pclk) disable iff (!presetn)
    $rose(irq_sts_q[IRQ_THR_BIT]) |-> ({3'b000, $past(fifo_count)} >= $past(fifo_level_threshold_q)) ||
                                     ({3'b000, $past(fifo_count, 2)} >= $past(fifo_level_threshold_q));
  endproperty
  a_thr_flag_level: assert property (p_thr_flag_level) else $error("threshold flag below level");

  property p_thr_range;
    @(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && is_thr && pwdata[7:0] > FIFO_THR_MAX) |-> pslverr ##1 $stable(fifo_level_threshold_q);
  endproperty
  a_thr_range: assert property (p_thr_range) else $error("oversize threshold accepted");

  property p_powered_only;
    @(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && is_cfg && !power_q) |=> $stable(filt_cfg_q);
  endproperty
  a_powered_only: assert property (p_powered_only) else $error("setting written while powered down");

  property p_cts_after_write;
    @(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && is_prop && power_q && !pslverr) |=> irq_sts_q[IRQ_CTS_BIT];
  endproperty
  a_cts_after_write: assert property (p_cts_after_write) else $error("no completion after setting write");

  property p_reject_over_limit;
    @(posedge pclk) disable iff (!presetn)
    (group_valid && (eff_lvl_b > second_block_error_limit || eff_lvl_a > first_block_error_limit)) |->
      !fifo_wr_valid;
  endproperty
  a_reject_over_limit: assert property (p_reject_over_limit) else $error("group over limit stored");

  property p_disabled_no_store;
    @(posedge pclk) disable iff (!presetn)
    !filt_cfg_q[CFG_ENABLE_BIT] |-> !fifo_wr_valid ##1 (stored_q == 1'b0);
  endproperty
  a_disabled_no_store: assert property (p_disabled_no_store) else $error("group stored while disabled");

  property p_levels_kept;
    @(posedge pclk) disable iff (!presetn)
    fifo_wr_valid |-> fifo_wr_data.lvl_c == eff_lvl_c && fifo_wr_data.blk_c == group_in.blk_c;
  endproperty
  a_levels_kept: assert property (p_levels_kept) else $error("error level not stored with group");

  property p_low_conf_uncorr;
    @(posedge pclk) disable iff (!presetn)
    (group_valid && conf_in.conf_d < conf_q[CONF_D_LSB +: 4]) |-> eff_lvl_d == LVL_UNCORR;
  endproperty
  a_low_conf_uncorr: assert property (p_low_conf_uncorr) else $error("low confidence not uncorrectable");

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
    (irq_sts_q[IRQ_THR_BIT] && irq_en_q[IRQ_THR_BIT]) |=> data_service_interrupt;
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt missing");

  property p_irq_quiet;
    @(posedge pclk) disable iff (!presetn)
    ((irq_sts_q & irq_en_q) == '0) |=> !data_service_interrupt;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without enabled cause");

  property p_overflow_flag;
    @(posedge pclk) disable iff (!presetn)
    (fifo_wr_valid && !fifo_wr_ready) |=> irq_sts_q[IRQ_OVF_BIT];
  endproperty
  a_overflow_flag: assert property (p_overflow_flag) else $error("dropped group not flagged");

  property p_flag_after_store;
    @(posedge pclk) disable iff (!presetn)
    group_threshold_flag |-> $past(fifo_wr_valid && fifo_wr_ready);
  endproperty
  a_flag_after_store: assert property (p_flag_after_store) else $error("threshold flag without store");

  property p_ready_once;
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held over one cycle");

endmodule
`default_nettype wire

/* inc/rds_filter_pkg.sv */
// Constants, field layouts and carrier types of the group filter block
package rds_filter_pkg;

  // Setting indices; byte address is four times the index
  localparam logic [15:0] IDX_FIFO_THR  = 16'h1501;
  localparam logic [15:0] IDX_FILT_CFG  = 16'h1502;
  localparam logic [15:0] IDX_CONF      = 16'h1503;
  localparam logic [15:0] ADDR_FIFO_THR = {IDX_FIFO_THR[13:0], 2'b00};
  localparam logic [15:0] ADDR_FILT_CFG = {IDX_FILT_CFG[13:0], 2'b00};
  localparam logic [15:0] ADDR_CONF     = {IDX_CONF[13:0], 2'b00};

  // Block-local registers
  localparam logic [15:0] ADDR_POWER     = 16'h6000;
  localparam logic [15:0] ADDR_GROUP_AB  = 16'h6004;
  localparam logic [15:0] ADDR_GROUP_CD  = 16'h6008;
  localparam logic [15:0] ADDR_GROUP_STS = 16'h600C;
  localparam logic [15:0] ADDR_GROUP_POP = 16'h6010;
  localparam logic [15:0] ADDR_IRQ_STS   = 16'h6014;
  localparam logic [15:0] ADDR_IRQ_EN    = 16'h6018;
  localparam logic [15:0] ADDR_IRQ_CLR   = 16'h601C;

  // Reset values and the threshold maximum
  localparam logic [7:0]  FIFO_THR_RST = 8'h00;
  localparam logic [15:0] FILT_CFG_RST = 16'h0000;
  localparam logic [15:0] CONF_RST     = 16'h1111;
  localparam logic [7:0]  FIFO_THR_MAX = 8'h0E;

  // Field positions
  localparam int CFG_ENABLE_BIT = 0;
  localparam int CFG_LIM_A_LSB  = 14;
  localparam int CFG_LIM_B_LSB  = 12;
  localparam int CFG_LIM_C_LSB  = 10;
  localparam int CFG_LIM_D_LSB  = 8;
  localparam int CONF_B_LSB     = 8;
  localparam int CONF_C_LSB     = 4;
  localparam int CONF_D_LSB     = 0;
  localparam int POWER_UP_BIT   = 0;
  localparam int POP_BIT        = 0;
  localparam int GSTS_VALID_BIT = 8;
  localparam int GSTS_CNT_LSB   = 16;

  // Interrupt status layout
  localparam int IRQ_W       = 3;
  localparam int IRQ_THR_BIT = 0;
  localparam int IRQ_CTS_BIT = 1;
  localparam int IRQ_OVF_BIT = 2;

  // Block error level codes
  localparam logic [1:0] LVL_NONE   = 2'h0;
  localparam logic [1:0] LVL_FEW    = 2'h1;
  localparam logic [1:0] LVL_MANY   = 2'h2;
  localparam logic [1:0] LVL_UNCORR = 2'h3;

  // Group store
  localparam int              FIFO_DEPTH = 16;
  localparam int              PTR_W      = 4;
  localparam int              CNT_W      = 5;
  localparam logic [CNT_W-1:0] FIFO_FULL = 5'h10;

  typedef struct packed {
    logic [15:0] blk_a;
    logic [15:0] blk_b;
    logic [15:0] blk_c;
    logic [15:0] blk_d;
    logic [1:0]  lvl_a;
    logic [1:0]  lvl_b;
    logic [1:0]  lvl_c;
    logic [1:0]  lvl_d;
  } group_s;

  typedef struct packed {
    logic [3:0] conf_b;
    logic [3:0] conf_c;
    logic [3:0] conf_d;
  } conf_s;

endpackage

/* test/host_model.sv */
// Host controller model: APB master issuing setting and status commands
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [15:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h00000000;
  end

  // Starts on a fresh edge so back-to-back calls never reassign psel in one step
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines show no stale value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench of the group filter block
`timescale 1ns/10ps
`default_nettype none
module testbench
  import rds_filter_pkg::*;
;
  logic        pclk;
  logic        presetn;
  wire         psel;
  wire         penable;
  wire         pwrite;
  wire  [15:0] paddr;
  wire  [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         data_service_interrupt;
  logic        group_valid;
  group_s      group_in;
  conf_s       conf_in;
  logic        last_err;
  logic [31:0] r;
  int          err_count;
  int          checks_done;
  int          cyc;
  int          seq;
  group_s      exp_q[$];
  logic [7:0]  lims[4] = '{8'hAA, 8'hFF, 8'h00, 8'hEF};
  logic [7:0]  pats[5] = '{8'h00, 8'hEF, 8'hAA, 8'h70, 8'h14};

  rds_group_filter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .group_valid(group_valid), .group_in(group_in), .conf_in(conf_in),
    .data_service_interrupt(data_service_interrupt));
  host_model host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] x;
    host_u.xfer(1'b1, a, d, x, last_err);
  endtask

  task automatic rd(input logic [15:0] a);
    host_u.xfer(1'b0, a, 32'h00000000, r, last_err);
  endtask

  function automatic logic fits(input logic [7:0] lv, input logic [7:0] lim);
    for (int i = 0; i < 4; i++) if (lv[2*i+:2] > lim[2*i+:2]) return 1'b0;
    return 1'b1;
  endfunction

  // elv is the level the store should report back after confidence gating
  task automatic send(input logic [7:0] lv, input logic [11:0] cf, input logic [7:0] elv, input logic keep);
    group_s g;
    seq = seq + 1;
    g = {seq[15:0], ~seq[15:0], 16'hA5C3, seq[15:0] ^ 16'h5A5A, lv};
    @(posedge pclk);
    group_valid <= 1'b1;
    group_in    <= g;
    conf_in     <= cf;
    @(posedge pclk);
    group_valid <= 1'b0;
    group_in    <= ~g;
    g[7:0] = elv;
    if (keep) exp_q.push_back(g);
  endtask

  task automatic count_is(input int n);
    rd(ADDR_GROUP_STS);
    check("count", {27'h0, r[20:16]}, n);
  endtask

  task automatic drain;
    group_s g;
    while (exp_q.size() > 0) begin
      g = exp_q.pop_front();
      rd(ADDR_GROUP_AB);
      check("head_ab", r, {g.blk_a, g.blk_b});
      rd(ADDR_GROUP_CD);
      check("head_cd", r, {g.blk_c, g.blk_d});
      rd(ADDR_GROUP_STS);
      check("head_lv", {23'h0, r[8:0]}, {23'h0, 1'b1, g[7:0]});
      wr(ADDR_GROUP_POP, 32'h00000001);
    end
    count_is(0);
  endtask

  task automatic t_regs;
    rd(ADDR_FIFO_THR);
    check("off_err", {31'h0, last_err}, 32'h1);
    wr(ADDR_FILT_CFG, 32'h0000FF01);
    check("off_wr_err", {31'h0, last_err}, 32'h1);
    wr(ADDR_POWER, 32'h00000001);
    rd(ADDR_FIFO_THR);
    check("thr_rst", r, 32'h0);
    @(negedge pclk);
    check("ready_once", {31'h0, pready}, 32'h0);
    rd(ADDR_FILT_CFG);
    check("cfg_rst", r, 32'h0);
    rd(ADDR_CONF);
    check("conf_rst", r, 32'h1111);
    wr(ADDR_FIFO_THR, 32'h0000000F);
    check("thr_err", {31'h0, last_err}, 32'h1);
    wr(ADDR_FIFO_THR, 32'h0000000E);
    rd(ADDR_FIFO_THR);
    check("thr_max", r, 32'hE);
    wr(ADDR_FILT_CFG, 32'hFFFFFFFF);
    rd(ADDR_FILT_CFG);
    check("cfg_fields", r, 32'hFF01);
    wr(ADDR_CONF, 32'hFFFFFFFF);
    rd(ADDR_CONF);
    check("conf_fields", r, 32'hFFF);
    rd(ADDR_IRQ_STS);
    check("cts", {31'h0, r[IRQ_CTS_BIT]}, 32'h1);
    rd(16'h6020);
    check("unmapped", {31'h0, last_err}, 32'h1);
    wr(ADDR_FIFO_THR, 32'h0);
    $display("test regs done");
  endtask

  task automatic t_filter;
    wr(ADDR_FILT_CFG, 32'h0000FF00);
    send(8'h00, 12'hFFF, 8'h00, 1'b0);
    count_is(0);
    foreach (lims[i]) begin
      wr(ADDR_FILT_CFG, {16'h0, lims[i], 8'h01});
      foreach (pats[j]) begin
        send(pats[j], 12'hFFF, pats[j], fits(pats[j], lims[i]));
        count_is(exp_q.size());
      end
    end
    drain();
    $display("test filter done");
  endtask

  task automatic t_conf;
    wr(ADDR_CONF, 32'h00000555);
    wr(ADDR_FILT_CFG, 32'h0000AA01);
    send(8'h00, 12'h455, 8'h00, 1'b0);
    send(8'h00, 12'h555, 8'h00, 1'b1);
    wr(ADDR_FILT_CFG, 32'h0000FF01);
    send(8'h00, 12'h524, 8'h0F, 1'b1);
    count_is(2);
    drain();
    $display("test confidence done");
  endtask

  task automatic t_irq;
    wr(ADDR_IRQ_CLR, 32'h00000007);
    wr(ADDR_IRQ_EN, 32'h00000001);
    wr(ADDR_FIFO_THR, 32'h00000003);
    send(8'h00, 12'hFFF, 8'h00, 1'b1);
    send(8'h00, 12'hFFF, 8'h00, 1'b1);
    rd(ADDR_IRQ_STS);
    check("below_thr", {31'h0, r[IRQ_THR_BIT]}, 32'h0);
    check("irq_low", {31'h0, data_service_interrupt}, 32'h0);
    send(8'h00, 12'hFFF, 8'h00, 1'b1);
    rd(ADDR_IRQ_STS);
    check("at_thr", {31'h0, r[IRQ_THR_BIT]}, 32'h1);
    check("irq_high", {31'h0, data_service_interrupt}, 32'h1);
    wr(ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check("irq_masked", {31'h0, data_service_interrupt}, 32'h0);
    wr(ADDR_IRQ_EN, 32'h00000001);
    wr(ADDR_IRQ_CLR, 32'h00000001);
    rd(ADDR_IRQ_STS);
    check("thr_cleared", {31'h0, r[IRQ_THR_BIT]}, 32'h0);
    check("irq_cleared", {31'h0, data_service_interrupt}, 32'h0);
    drain();
    $display("test interrupt done");
  endtask

  task automatic t_full;
    wr(ADDR_IRQ_CLR, 32'h00000007);
    for (int i = 0; i < 17; i++) send(8'h00, 12'hFFF, 8'h00, i < 16);
    count_is(16);
    rd(ADDR_IRQ_STS);
    check("overflow", {31'h0, r[IRQ_OVF_BIT]}, 32'h1);
    drain();
    $display("test full done");
  endtask

  initial begin
    err_count   = 0;
    checks_done = 0;
    cyc         = 0;
    seq         = 0;
    presetn     = 1'b0;
    group_valid = 1'b0;
    group_in    = '0;
    conf_in     = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_filter();
    t_conf();
    t_irq();
    t_full();
    stop_test();
  end
endmodule
`default_nettype wire
